// ==== include/isds_pkg.sv ====
/*
 types shared by the sync detect block; assumes isds_regs.svh constants
*/
package isds_pkg;

	typedef struct packed {
		logic present;
		logic pol_pos;
		logic [11:0] count;
	} isds_meas_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] index;
	} isds_aphase_t;

	typedef enum logic [2:0] {
		ISDS_LOST = 3'h1,
		ISDS_SEEN = 3'h2,
		ISDS_LOCK = 3'h4
	} isds_lock_t;

endpackage

// ==== include/isds_regs.svh ====
/*
 register indices, field positions, reset values and limits of the
 input sync detect and status block; assumes word-aligned 32-bit bus
*/
`ifndef ISDS_REGS_SVH
`define ISDS_REGS_SVH

`define ISDS_IDX_SCRATCH 8'h02
`define ISDS_IDX_STATE 8'h03
`define ISDS_IDX_SYNC 8'h04
`define ISDS_IDX_LINES_LO 8'h05
`define ISDS_IDX_LINES_HI 8'h06
`define ISDS_IDX_CLKS_LO 8'h07
`define ISDS_IDX_CLKS_HI 8'h08
`define ISDS_IDX_CONFIG1 8'h18
`define ISDS_IDX_INT_STAT 8'h40
`define ISDS_IDX_INT_MASK 8'h41
`define ISDS_IDX_PORT_PTR 8'h42
`define ISDS_IDX_PORT_DATA 8'h43

`define ISDS_ADDR_LSB 2
`define ISDS_ADDR_MSB 9

`define ISDS_BIT_INT_STATE 0
`define ISDS_BIT_HS_ABSENT 0
`define ISDS_BIT_VS_ABSENT 1
`define ISDS_BIT_HS_POL 2
`define ISDS_BIT_VS_POL 3
`define ISDS_BIT_INT_ACK 6

`define ISDS_EV_HS_CHG 0
`define ISDS_EV_VS_CHG 1
`define ISDS_EV_FRAME 2
`define ISDS_EV_NUM 3

`define ISDS_RST_BYTE 8'h00
`define ISDS_RST_WORD 32'h0000_0000
`define ISDS_RST_EV 3'h0
`define ISDS_RST_PTR 3'h0
`define ISDS_RST_CNT 12'h000

`define ISDS_HS_LIMIT 12'hFFF
`define ISDS_VS_LIMIT 12'h7FF
`define ISDS_PORT_DEPTH 8
`define ISDS_HTRANS_NONSEQ 2'h2
`define ISDS_HTRANS_SEQ 2'h3

`endif

// ==== src/isds_sync_meas.sv ====
/*
 period, polarity and presence measure for one sync input;
 assumes sync_i synchronous to ref_clk_i and tick_i a one-cycle enable
*/
`timescale 1ns/1ps
`include "isds_regs.svh"

module isds_sync_meas #(
	parameter logic [11:0] LIMIT = `ISDS_HS_LIMIT
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic sync_i,
	input wire logic tick_i,
	output isds_pkg::isds_meas_t meas_o,
	output logic lead_o,
	output logic new_o,
	output logic chg_o
);

	logic sync_q;
	logic armed_q;
	logic [11:0] cnt_q;
	logic [11:0] cnt_d;
	logic [11:0] high_q;
	logic [11:0] high_d;
	isds_pkg::isds_meas_t meas_q;
	isds_pkg::isds_lock_t st_q;
	isds_pkg::isds_lock_t st_d;

	// edges ignored until one real sample is held: no false edge at reset
	wire rise = armed_q & sync_i & ~sync_q;
	wire fall = armed_q & ~sync_i & sync_q;
	wire sat = (cnt_q == LIMIT);
	wire [11:0] low_cnt = cnt_q - high_q;
	// pulse is the shorter phase of the period
	wire pol_now = (high_q < low_cnt);
	wire locked_rise = rise & (st_q != isds_pkg::ISDS_LOST);

	// saturating counts, restarted on each rising edge
	assign cnt_d = rise ? `ISDS_RST_CNT :
		(sat ? cnt_q : cnt_q + 12'(tick_i));
	assign high_d = rise ? `ISDS_RST_CNT :
		(sat ? high_q : high_q + 12'(tick_i & sync_i));

	always_comb begin
		case (st_q)
			isds_pkg::ISDS_LOST: st_d = rise ? isds_pkg::ISDS_SEEN : st_q;
			isds_pkg::ISDS_SEEN: st_d = sat ? isds_pkg::ISDS_LOST :
				(rise ? isds_pkg::ISDS_LOCK : st_q);
			isds_pkg::ISDS_LOCK: st_d = sat ? isds_pkg::ISDS_LOST : st_q;
			default: st_d = isds_pkg::ISDS_LOST;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync_q <= 1'b0;
			armed_q <= 1'b0;
			cnt_q <= `ISDS_RST_CNT;
			high_q <= `ISDS_RST_CNT;
			st_q <= isds_pkg::ISDS_LOST;
			meas_q <= '0;
		end else begin
			sync_q <= sync_i;
			armed_q <= 1'b1;
			cnt_q <= cnt_d;
			high_q <= high_d;
			st_q <= st_d;
			meas_q.present <= (st_d == isds_pkg::ISDS_LOCK);
			if (locked_rise) begin
				meas_q.count <= cnt_q;
				meas_q.pol_pos <= pol_now;
			end
		end
	end

	assign meas_o = meas_q;
	assign lead_o = meas_q.pol_pos ? rise : fall;
	assign new_o = locked_rise & ~sat;
	assign chg_o = (st_d == isds_pkg::ISDS_LOCK) != meas_q.present;

endmodule

// ==== src/isds_top.sv ====
/*
 input sync detect and status block with an AHB-Lite register slave;
 assumes hsync_i and vsync_i synchronous to ref_clk_i, one bus master,
 single word transfers, and hready_i tied to this slave's hreadyout_o
*/
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "isds_regs.svh"

module isds_top (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic hsync_i,
	input wire logic vsync_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic irq_o
);

	function automatic logic hit(
		input logic [7:0] index,
		input logic [7:0] target
	);
		hit = (index == target);
	endfunction

	// measurement results
	isds_pkg::isds_meas_t hs_meas;
	isds_pkg::isds_meas_t vs_meas;
	logic hs_lead;
	logic hs_new;
	logic hs_chg;
	logic vs_new;
	logic vs_chg;

	// bus pipeline
	isds_pkg::isds_aphase_t aph_q;
	isds_pkg::isds_aphase_t aph_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// software state
	logic [7:0] scratch_q;
	logic [`ISDS_EV_NUM-1:0] stat_q;
	logic [`ISDS_EV_NUM-1:0] mask_q;
	logic [`ISDS_EV_NUM-1:0] ev;
	logic [`ISDS_EV_NUM-1:0] stat_d;
	logic [2:0] ptr_q;
	logic [2:0] ptr_d;
	logic [7:0] port_mem [`ISDS_PORT_DEPTH];
	logic irq_q;

	// hsync period in clocks; every clock is a tick
	isds_sync_meas #(
		.LIMIT(`ISDS_HS_LIMIT)
	) u_hs_meas (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.sync_i(hsync_i),
		.tick_i(1'b1),
		.meas_o(hs_meas),
		.lead_o(hs_lead),
		.new_o(hs_new),
		.chg_o(hs_chg)
	);

	// vsync period in lines; the hsync leading edge is the tick
	isds_sync_meas #(
		.LIMIT(`ISDS_VS_LIMIT)
	) u_vs_meas (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.sync_i(vsync_i),
		.tick_i(hs_lead),
		.meas_o(vs_meas),
		.lead_o(),
		.new_o(vs_new),
		.chg_o(vs_chg)
	);

	// address phase decode
	wire aph_take = hsel_i & hready_i & htrans_i[1];
	wire [7:0] a_idx = haddr_i[`ISDS_ADDR_MSB:`ISDS_ADDR_LSB];

	assign aph_d.valid = aph_take;
	assign aph_d.write = hwrite_i;
	assign aph_d.index = a_idx;

	// data phase write strobes
	wire wr_ok = aph_q.valid & aph_q.write;
	wire [7:0] w_idx = aph_q.index;
	wire [7:0] wbyte = hwdata_i[7:0];
	wire wr_scratch = wr_ok & hit(w_idx, `ISDS_IDX_SCRATCH);
	wire wr_cfg1 = wr_ok & hit(w_idx, `ISDS_IDX_CONFIG1);
	wire wr_stat = wr_ok & hit(w_idx, `ISDS_IDX_INT_STAT);
	wire wr_mask = wr_ok & hit(w_idx, `ISDS_IDX_INT_MASK);
	wire wr_ptr = wr_ok & hit(w_idx, `ISDS_IDX_PORT_PTR);
	wire wr_port = wr_ok & hit(w_idx, `ISDS_IDX_PORT_DATA);

	// acknowledge drops every pending event at once
	wire int_ack = wr_cfg1 & wbyte[`ISDS_BIT_INT_ACK];

	// address-phase read selection, registered into the data phase
	wire rd_take = aph_take & ~hwrite_i;
	wire [7:0] lines_lo = vs_meas.count[7:0];
	wire [7:0] lines_hi = {5'h00, vs_meas.count[10:8]};
	wire [7:0] clks_lo = hs_meas.count[7:0];
	wire [7:0] clks_hi = {4'h0, hs_meas.count[11:8]};
	wire [7:0] state_byte = {7'h00, ~irq_q};
	wire [7:0] sync_byte = {4'h0,
		vs_meas.pol_pos,
		hs_meas.pol_pos,
		~vs_meas.present,
		~hs_meas.present};
	wire [7:0] stat_byte = {5'h00, stat_q};
	wire [7:0] mask_byte = {5'h00, mask_q};
	wire [7:0] ptr_byte = {5'h00, ptr_q};
	wire [7:0] port_byte = port_mem[ptr_q];

	// a port read whose address phase meets a port write data phase sees the unstepped slot
	always_comb begin
		case (a_idx)
			`ISDS_IDX_SCRATCH: rdata_d = {24'h000000, scratch_q};
			`ISDS_IDX_STATE: rdata_d = {24'h000000, state_byte};
			`ISDS_IDX_SYNC: rdata_d = {24'h000000, sync_byte};
			`ISDS_IDX_LINES_LO: rdata_d = {24'h000000, lines_lo};
			`ISDS_IDX_LINES_HI: rdata_d = {24'h000000, lines_hi};
			`ISDS_IDX_CLKS_LO: rdata_d = {24'h000000, clks_lo};
			`ISDS_IDX_CLKS_HI: rdata_d = {24'h000000, clks_hi};
			`ISDS_IDX_INT_STAT: rdata_d = {24'h000000, stat_byte};
			`ISDS_IDX_INT_MASK: rdata_d = {24'h000000, mask_byte};
			`ISDS_IDX_PORT_PTR: rdata_d = {24'h000000, ptr_byte};
			`ISDS_IDX_PORT_DATA: rdata_d = {24'h000000, port_byte};
			default: rdata_d = `ISDS_RST_WORD;
		endcase
	end

	// interrupt events
	assign ev[`ISDS_EV_HS_CHG] = hs_chg;
	assign ev[`ISDS_EV_VS_CHG] = vs_chg;
	assign ev[`ISDS_EV_FRAME] = vs_new;

	// set beats clear so no event is lost in the clearing cycle
	genvar gi;
	generate
		for (gi = 0; gi < `ISDS_EV_NUM; gi++) begin : g_stat
			wire clr = (wr_stat & wbyte[gi]) | int_ack;
			assign stat_d[gi] = ev[gi] | (stat_q[gi] & ~clr);
		end
	endgenerate

	wire irq_d = |(stat_d & mask_q);

	// port pointer: explicit load, else step on every port write
	assign ptr_d = wr_ptr ? wbyte[2:0] :
		(wr_port ? ptr_q + 3'h1 : ptr_q);

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aph_q <= '0;
			rdata_q <= `ISDS_RST_WORD;
		end else begin
			if (hready_i) begin
				aph_q <= aph_d;
			end
			if (rd_take) begin
				rdata_q <= rdata_d;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scratch_q <= `ISDS_RST_BYTE;
		end else if (wr_scratch) begin
			scratch_q <= wbyte;
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stat_q <= `ISDS_RST_EV;
			mask_q <= `ISDS_RST_EV;
			irq_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			irq_q <= irq_d;
			if (wr_mask) begin
				mask_q <= wbyte[`ISDS_EV_NUM-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ptr_q <= `ISDS_RST_PTR;
		end else begin
			ptr_q <= ptr_d;
		end
	end

	// port storage has no reset; software fills it before use
	always_ff @(posedge ref_clk_i) begin
		if (wr_port) begin
			port_mem[ptr_q] <= wbyte;
		end
	end

	// zero wait states, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = rdata_q;
	assign irq_o = irq_q;

endmodule

// ==== verif/isds_chk.sv ====
/*
 bus and status checker of the sync detect block;
 bound to isds_top, one clock and one reset
*/
`timescale 1ns/1ps
module isds_chk (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic irq_o
);
	logic rd;
	logic wr;
	logic [7:0] ix;
	logic sw_q;
	logic [7:0] sc_q;
	assign ix = haddr_i[9:2];
	assign rd = hsel_i & htrans_i[1] & ~hwrite_i & hreadyout_o;
	assign wr = hsel_i & htrans_i[1] & hwrite_i & hreadyout_o & ix == 8'h02;
	// shadow of the scratch byte, written at the end of the data phase
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sw_q <= 1'b0;
			sc_q <= 8'h00;
		end else begin
			sw_q <= wr;
			if (sw_q)
				sc_q <= hwdata_i[7:0];
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	bus_okay_a: assert property (hreadyout_o && !hresp_o)
		else $error("bus slave not ready or not okay");
	// past value: a read beside a write data phase sees the old byte
	scratch_read_a: assert property (rd && ix == 8'h02 |=>
		hrdata_o == {24'h0, $past(sc_q)}) else $error("scratch mismatch");
	irq_state_a: assert property (rd && ix == 8'h03 |=>
		hrdata_o == {31'h0, !$past(irq_o)}) else $error("state mismatch");
	sync_width_a: assert property (rd && ix == 8'h04 |=>
		hrdata_o[31:4] == 28'h0) else $error("sync byte too wide");
	lines_high_a: assert property (rd && ix == 8'h06 |=>
		hrdata_o[31:3] == 29'h0) else $error("line count too wide");
	clocks_high_a: assert property (rd && ix == 8'h08 |=>
		hrdata_o[31:4] == 28'h0) else $error("clock count too wide");
	port_width_a: assert property (rd && ix == 8'h43 |=>
		hrdata_o[31:8] == 24'h0) else $error("port byte too wide");
	rdata_hold_a: assert property (!rd |=> $stable(hrdata_o))
		else $error("read data moved without a read");
endmodule
bind isds_top isds_chk i_isds_chk (.ref_clk_i, .arst_n_i, .hsel_i,
	.haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hrdata_o, .hreadyout_o,
	.hresp_o, .irq_o);

// ==== verif/isds_sync_src.sv ====
/*
 sync source model: hsync and vsync of chosen period
 and polarity; runs on the bench clock
*/
`timescale 1ns/1ps
module isds_sync_src (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic run_i,
	input wire logic hpol_i,
	input wire logic vpol_i,
	input wire logic [11:0] hper_i,
	input wire logic [10:0] vlines_i,
	output logic hsync_o,
	output logic vsync_o
);
	logic [11:0] hc_q;
	logic [10:0] lc_q;
	logic eol;
	assign eol = hc_q >= hper_i - 12'h1;
	// stopped source rests at its idle level, so no edges at all
	assign hsync_o = hpol_i ~^ (run_i && hc_q < 12'h4);
	assign vsync_o = vpol_i ~^ (run_i && lc_q < 11'h2);
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hc_q <= 12'h0;
			lc_q <= 11'h0;
		end else if (run_i) begin
			hc_q <= eol ? 12'h0 : hc_q + 12'h1;
			if (eol)
				lc_q <= lc_q >= vlines_i - 11'h1 ? 11'h0 : lc_q + 11'h1;
		end
	end
endmodule

// ==== verif/test_isds_top.sv ====
/*
 self-checking bench of the sync detect block;
 drives the AHB-Lite slave and a sync source model
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
	n_errors++; $display("FAIL %s exp %h got %h", n, e, s); end end
module test_isds_top;
	logic ref_clk_i = 0, arst_n_i = 0, hsel_i = 0, hwrite_i = 0;
	logic run = 0, hpol = 0, vpol = 0, rd_dp = 0;
	logic hsync, vsync, hreadyout_o, hresp_o, irq_o;
	logic [1:0] htrans_i = 2'h0;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
	logic [31:0] rnd = 32'hA0B76E74;
	logic [11:0] hper = 12'h020;
	logic [10:0] vl = 11'h005;
	logic [63:0] q[$];
	logic [63:0] e;
	logic [7:0] b[3];
	int n_errors = 0, tests_run = 0;
	isds_top i_isds_top (.ref_clk_i, .arst_n_i, .hsync_i(hsync),
		.vsync_i(vsync), .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
		.hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
		.hreadyout_o, .hresp_o, .irq_o);
	isds_sync_src i_isds_sync_src (.clk_i(ref_clk_i), .arst_n_i,
		.run_i(run), .hpol_i(hpol), .vpol_i(vpol), .hper_i(hper),
		.vlines_i(vl), .hsync_o(hsync), .vsync_o(vsync));
	initial forever #4 ref_clk_i = ~ref_clk_i;
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task xfer(input logic w, input logic [7:0] ix, input logic [31:0] d);
		@(posedge ref_clk_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {22'h0, ix, 2'h0};
		hwrite_i <= w;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
	endtask
	task rd(input logic [7:0] ix, input logic [31:0] x, input logic [31:0] m);
		rnd = nx(rnd);
		q.push_back({m, x});
		xfer(1'b0, ix, rnd);
	endtask
	// read data is taken at the edge that ends the data phase
	always @(posedge ref_clk_i) begin
		if (rd_dp && hreadyout_o === 1'b1 && q.size() > 0) begin
			e = q.pop_front();
			`CHK("hrdata", e[31:0], hrdata_o & e[63:32])
		end
		rd_dp <= hsel_i & htrans_i[1] & ~hwrite_i & hreadyout_o;
	end
	task end_sim;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (98000) @(posedge ref_clk_i);
		n_errors++;
		end_sim;
	end
	initial begin
		logic [11:0] hp;
		logic [11:0] m;
		logic [10:0] v;
		repeat (20) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		rnd = nx(rnd);
		xfer(1'b1, 8'h02, rnd);
		rd(8'h02, {24'h0, rnd[7:0]}, 32'hFFFFFFFF);
		rd(8'h20, 32'h0, 32'hFFFFFFFF);
		rd(8'h04, 32'h3, 32'h3);
		rd(8'h03, 32'h1, 32'h1);
		xfer(1'b1, 8'h42, 32'h0);
		for (int i = 0; i < 3; i++) begin
			rnd = nx(rnd);
			b[i] = rnd[7:0];
			xfer(1'b1, 8'h43, rnd);
		end
		rd(8'h42, 32'h3, 32'h7);
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, 8'h42, i);
			rd(8'h43, {24'h0, b[i]}, 32'hFF);
		end
		xfer(1'b1, 8'h41, 32'h1);
		run <= 1'b1;
		repeat (200) @(posedge ref_clk_i);
		`CHK("irq", 1'b1, irq_o)
		rd(8'h03, 32'h0, 32'h1);
		xfer(1'b1, 8'h18, 32'h40);
		rd(8'h03, 32'h1, 32'h1);
		// odd line counts: the high byte sees no borrow from the minus one
		for (int p = 0; p < 4; p++) begin
			rnd = nx(rnd);
			v = p[0] ? 11'h105 : 11'h005;
			hp = p[0] ? 12'h020 : {3'h1, rnd[8:0]};
			m = hp - 12'h1;
			hpol <= p[0];
			vpol <= p[1];
			vl <= v;
			hper <= hp;
			repeat (3 * int'(v) * int'(hp)) @(posedge ref_clk_i);
			rd(8'h04, {28'h0, p[1:0], 2'h0}, 32'hF);
			rd(8'h05, {24'h0, v[7:0] - 8'h1}, 32'hFF);
			rd(8'h06, {29'h0, v[10:8]}, 32'hFF);
			rd(8'h07, {24'h0, m[7:0]}, 32'hFF);
			rd(8'h08, {28'h0, m[11:8]}, 32'hFF);
		end
		`CHK("irq", 1'b0, irq_o)
		xfer(1'b1, 8'h40, 32'h7);
		run <= 1'b0;
		repeat (4200) @(posedge ref_clk_i);
		`CHK("irq", 1'b1, irq_o)
		rd(8'h04, 32'h1, 32'h1);
		xfer(1'b1, 8'h40, 32'h1);
		rd(8'h03, 32'h1, 32'h1);
		end_sim;
	end
endmodule
